/* mcfg_pkg.sv */
// Package for the communication settings and trip monitor register bank
package mcfg_pkg;

    // Register offsets (word index on the plain register port)
    localparam logic [7:0] REG_STATION_ADDR   = 8'h00;
    localparam logic [7:0] REG_LINE_BIT_RATE  = 8'h01;
    localparam logic [7:0] REG_CHAR_FORMAT    = 8'h02;
    localparam logic [7:0] REG_LINK_WATCH     = 8'h03;
    localparam logic [7:0] REG_CMD_CHANNEL    = 8'h04;
    localparam logic [7:0] REG_ADVANCED_MODE  = 8'h05;
    localparam logic [7:0] REG_HIST_CLEAR     = 8'h06;
    localparam logic [7:0] REG_STATUS         = 8'h07;
    localparam logic [7:0] REG_START_DURATION = 8'h10;
    localparam logic [7:0] REG_START_PEAK     = 8'h11;
    localparam logic [7:0] REG_LATEST_TRIP    = 8'h12;
    localparam logic [7:0] REG_TRIP_CURRENT   = 8'h13;
    localparam logic [7:0] REG_RUN_HOURS      = 8'h14;
    localparam logic [7:0] REG_START_COUNT    = 8'h15;
    localparam logic [7:0] REG_TRIP_COUNT     = 8'h16;
    localparam logic [7:0] REG_HISTORY_BASE   = 8'h20;
    localparam logic [7:0] REG_HISTORY_LAST   = 8'h28;

    // Setting encodings and limits
    localparam logic [7:0]  STATION_OFF       = 8'h00;
    localparam logic [7:0]  STATION_MAX       = 8'hF7;
    localparam logic [1:0]  RATE_4K8          = 2'h0;
    localparam logic [1:0]  RATE_9K6          = 2'h1;
    localparam logic [1:0]  RATE_19K2         = 2'h2;
    localparam logic [1:0]  FMT_EIGHT_ODD_ONE  = 2'h0;
    localparam logic [1:0]  FMT_EIGHT_EVEN_ONE = 2'h1;
    localparam logic [1:0]  FMT_EIGHT_NONE_ONE = 2'h2;
    localparam logic [1:0]  FMT_EIGHT_NONE_TWO = 2'h3;
    localparam logic        CHAN_TERMINAL     = 1'b0;
    localparam logic        CHAN_SERIAL       = 1'b1;
    localparam logic [9:0]  WATCH_MIN         = 10'h001;
    localparam logic [9:0]  WATCH_MAX         = 10'h258;
    localparam logic [9:0]  WATCH_DEFAULT     = 10'h032;
    localparam logic [9:0]  MEASURE_MAX       = 10'h3E7;
    localparam logic [15:0] COUNT_MAX         = 16'hFFFF;
    localparam logic [7:0]  HIST_CLEAR_KEY    = 8'h01;

    // Trip codes
    localparam logic [7:0]  TRIP_NONE              = 8'h00;
    localparam logic [7:0]  serial_link_fault_code = 8'h0B;

    // Timing: 10 MHz clock
    localparam int          CLOCK_HZ          = 10_000_000;
    localparam int          TENTH_CYCLES      = CLOCK_HZ / 10;
    localparam int          SECOND_CYCLES     = CLOCK_HZ;
    localparam int          HOUR_SECONDS      = 3600;
    localparam int          HISTORY_DEPTH     = 9;

    // Register port carrier
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
        logic        from_serial;
    } mcfg_req_t;

    // Motor state as seen by the monitor
    typedef struct packed {
        logic        stopped;
        logic        soft_ramp;
        logic        start_begin;
        logic        start_done;
        logic        running;
        logic        trip_event;
        logic [7:0]  trip_code;
        logic [9:0]  motor_current;
    } mcfg_motor_t;

endpackage : mcfg_pkg

/* mcfg_tick.sv */
// Free-running divider giving one-cycle strobes at a fixed period
`timescale 1ns/1ns
module mcfg_tick
    import mcfg_pkg::*;
#(
    parameter int PERIOD = TENTH_CYCLES
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // Control
    input  wire logic restart,
    output logic      tick
);
    logic [31:0] count;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count <= 32'h0;
            tick  <= 1'b0;
        end else if (restart) begin
            count <= 32'h0;
            tick  <= 1'b0;
        end else if (count == 32'(PERIOD - 1)) begin
            count <= 32'h0;
            tick  <= 1'b1;
        end else begin
            count <= count + 32'h1;
            tick  <= 1'b0;
        end
    end
endmodule : mcfg_tick

/* mcfg_satcnt.sv */
// Saturating event counter with synchronous clear
`timescale 1ns/1ns
module mcfg_satcnt
    import mcfg_pkg::*;
#(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         nrst,
    // Control
    input  wire logic         clear,
    input  wire logic         inc,
    output logic [W-1:0]      value
);
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            value <= '0;
        end else if (clear) begin
            // An event in the clear cycle still counts, so none is lost
            value <= W'(inc);
        end else if (inc && value != {W{1'b1}}) begin
            value <= value + W'(1);
        end
    end
endmodule : mcfg_satcnt

/* mcfg_bank.sv */
// Communication settings, command channel and trip monitor register bank
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
module mcfg_bank
    import mcfg_pkg::*;
(
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         nrst,
    // Register port
    input  wire mcfg_req_t    req,
    output logic [15:0]       rdata,
    output logic              write_rejected,
    output logic              illegal_function,
    // Motor state and pins
    input  wire mcfg_motor_t  motor,
    input  wire logic         logic_input_one,
    input  wire logic         forced_terminal_control,
    input  wire logic         link_frame_ok,
    input  wire logic         remote_run_request,
    // Outputs to the starter
    output logic              remote_run,
    output logic              link_trip,
    output logic              link_enabled,
    output logic [7:0]        active_station,
    output logic [1:0]        active_bit_rate,
    output logic [1:0]        active_format
);
    // Settings as written and as taken at power-on
    logic [7:0]  station_addr;
    logic [1:0]  line_bit_rate;
    logic [1:0]  char_format;
    logic [9:0]  link_watch_time;
    logic        cmd_channel;
    logic        advanced_mode_enable;
    logic        power_on_seen;

    logic [9:0]  last_start_duration;
    logic [9:0]  last_start_peak_current;
    logic [9:0]  start_seconds;
    logic [9:0]  start_peak;
    logic        starting;
    logic [7:0]  latest_trip_code;
    logic [9:0]  current_at_trip;
    logic [7:0]  trip_history [HISTORY_DEPTH];
    logic [11:0] hour_seconds;
    logic [9:0]  watch_count;
    logic        link_timeout;

    logic        wr_allowed;
    logic        wr_ok;
    logic        history_counter_clear;
    logic        any_trip;
    logic [7:0]  any_trip_code;
    logic        tenth_tick;
    logic        second_tick;
    logic [15:0] run_hours_total;
    logic [15:0] start_count_total;
    logic [15:0] trip_count_total;

    // Serial writes blocked by forced terminal control or soft ramps; every write blocked while the motor is not stopped
    always_comb begin
        wr_allowed = 1'b1;
        if (req.from_serial && forced_terminal_control) begin
            wr_allowed = 1'b0;
        end
        if (req.from_serial && motor.soft_ramp) begin
            wr_allowed = 1'b0;
        end
        if (!motor.stopped) begin
            wr_allowed = 1'b0;
        end
    end
    assign wr_ok = req.wr && wr_allowed;
    assign write_rejected = req.wr && !wr_allowed;
    assign illegal_function = req.wr && req.from_serial && forced_terminal_control;
    assign history_counter_clear = wr_ok && req.addr == REG_HIST_CLEAR
                                   && req.wdata[7:0] == HIST_CLEAR_KEY;

    // Writable settings; out-of-range values are ignored, except that command channel and advanced mode take bit 0 of any value
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            station_addr         <= STATION_OFF;
            line_bit_rate        <= RATE_19K2;
            char_format          <= FMT_EIGHT_EVEN_ONE;
            link_watch_time      <= WATCH_DEFAULT;
            cmd_channel          <= CHAN_TERMINAL;
            advanced_mode_enable <= 1'b0;
        end else if (wr_ok) begin
            unique case (req.addr)
                REG_STATION_ADDR: begin
                    if (req.wdata[15:8] == 8'h00 && req.wdata[7:0] <= STATION_MAX) begin
                        station_addr <= req.wdata[7:0];
                    end
                end
                REG_LINE_BIT_RATE: begin
                    if (req.wdata[1:0] <= RATE_19K2 && req.wdata[15:2] == 14'h0) begin
                        line_bit_rate <= req.wdata[1:0];
                    end
                end
                REG_CHAR_FORMAT: begin
                    if (req.wdata[15:2] == 14'h0) begin
                        char_format <= req.wdata[1:0];
                    end
                end
                REG_LINK_WATCH: begin
                    if (req.wdata[15:10] == 6'h0 && req.wdata[9:0] >= WATCH_MIN
                        && req.wdata[9:0] <= WATCH_MAX) begin
                        link_watch_time <= req.wdata[9:0];
                    end
                end
                REG_CMD_CHANNEL:   cmd_channel <= req.wdata[0];
                REG_ADVANCED_MODE: advanced_mode_enable <= req.wdata[0];
                default: ;
            endcase
        end
    end

    // Link settings are taken once, on the first clock after power-on
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            power_on_seen   <= 1'b0;
            active_station  <= STATION_OFF;
            active_bit_rate <= RATE_19K2;
            active_format   <= FMT_EIGHT_EVEN_ONE;
        end else if (!power_on_seen) begin
            power_on_seen   <= 1'b1;
            active_station  <= station_addr;
            active_bit_rate <= line_bit_rate;
            active_format   <= char_format;
        end
    end
    assign link_enabled = active_station != STATION_OFF;

    // Remote run needs the serial channel, input one high, no forced terminals
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            remote_run <= 1'b0;
        end else begin
            remote_run <= remote_run_request && cmd_channel == CHAN_SERIAL
                          && logic_input_one && !forced_terminal_control;
        end
    end

    mcfg_tick #(.PERIOD(TENTH_CYCLES)) u_tenth (
        .clock   (clock),
        .nrst    (nrst),
        .restart (1'b0),
        .tick    (tenth_tick)
    );

    mcfg_tick #(.PERIOD(SECOND_CYCLES)) u_second (
        .clock   (clock),
        .nrst    (nrst),
        .restart (1'b0),
        .tick    (second_tick)
    );

    // Link watch counts tenths since the last good frame; supervised only when enabled
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            watch_count  <= 10'h0;
            link_timeout <= 1'b0;
        end else if (!link_enabled || link_frame_ok) begin
            watch_count  <= 10'h0;
            link_timeout <= 1'b0;
        end else if (tenth_tick && !link_timeout) begin
            if (watch_count + 10'h1 >= link_watch_time) begin
                link_timeout <= 1'b1;
            end
            watch_count <= watch_count + 10'h1;
        end
    end
    // Only the first expiry trips; the flag holds until a frame arrives
    logic link_timeout_d;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            link_timeout_d <= 1'b0;
        end else begin
            link_timeout_d <= link_timeout;
        end
    end
    assign link_trip = link_timeout && !link_timeout_d;

    assign any_trip      = motor.trip_event || link_trip;
    assign any_trip_code = link_trip ? serial_link_fault_code : motor.trip_code;

    // Start duration and peak current measurement
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            starting                <= 1'b0;
            start_seconds           <= 10'h0;
            start_peak              <= 10'h0;
            last_start_duration     <= 10'h0;
            last_start_peak_current <= 10'h0;
        end else if (motor.start_begin) begin
            starting      <= 1'b1;
            start_seconds <= 10'h0;
            start_peak    <= motor.motor_current;
        end else if (starting) begin
            if (second_tick && start_seconds != MEASURE_MAX) begin
                start_seconds <= start_seconds + 10'h1;
            end
            if (motor.motor_current > start_peak) begin
                start_peak <= motor.motor_current;
            end
            if (motor.start_done) begin
                starting                <= 1'b0;
                last_start_duration     <= start_seconds;
                last_start_peak_current <= (start_peak > MEASURE_MAX) ? MEASURE_MAX
                                                                      : start_peak;
            end
        end
    end

    // Latest trip, trip current and history shift
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            latest_trip_code <= TRIP_NONE;
            current_at_trip  <= 10'h0;
        end else if (any_trip) begin
            latest_trip_code <= any_trip_code;
            current_at_trip  <= (motor.motor_current > MEASURE_MAX) ? MEASURE_MAX
                                                                    : motor.motor_current;
        end else if (history_counter_clear) begin
            latest_trip_code <= TRIP_NONE;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < HISTORY_DEPTH; gi++) begin : g_hist
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    trip_history[gi] <= TRIP_NONE;
                end else if (any_trip) begin
                    trip_history[gi] <= (gi == 0) ? latest_trip_code
                                                  : trip_history[(gi == 0) ? 0 : gi - 1];
                end else if (history_counter_clear) begin
                    trip_history[gi] <= TRIP_NONE;
                end
            end
        end
    endgenerate

    // Run hours: seconds of running accumulate into whole hours
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hour_seconds <= 12'h0;
        end else if (history_counter_clear) begin
            hour_seconds <= 12'h0;
        end else if (motor.running && second_tick) begin
            hour_seconds <= (hour_seconds == 12'(HOUR_SECONDS - 1)) ? 12'h0
                                                                    : hour_seconds + 12'h1;
        end
    end

    mcfg_satcnt #(.W(16)) u_hours (
        .clock (clock),
        .nrst  (nrst),
        .clear (history_counter_clear),
        .inc   (motor.running && second_tick
                && hour_seconds == 12'(HOUR_SECONDS - 1)),
        .value (run_hours_total)
    );

    mcfg_satcnt #(.W(16)) u_starts (
        .clock (clock),
        .nrst  (nrst),
        .clear (history_counter_clear),
        .inc   (motor.start_begin),
        .value (start_count_total)
    );

    mcfg_satcnt #(.W(16)) u_trips (
        .clock (clock),
        .nrst  (nrst),
        .clear (history_counter_clear),
        .inc   (any_trip),
        .value (trip_count_total)
    );

    // Read data one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata <= 16'h0;
        end else if (req.rd) begin
            rdata <= 16'h0;
            unique case (req.addr)
                REG_STATION_ADDR:   rdata <= {8'h0, station_addr};
                REG_LINE_BIT_RATE:  rdata <= {14'h0, line_bit_rate};
                REG_CHAR_FORMAT:    rdata <= {14'h0, char_format};
                REG_LINK_WATCH:     rdata <= {6'h0, link_watch_time};
                REG_CMD_CHANNEL:    rdata <= {15'h0, cmd_channel};
                REG_ADVANCED_MODE:  rdata <= {15'h0, advanced_mode_enable};
                REG_STATUS:         rdata <= {12'h0, link_timeout, link_enabled,
                                              remote_run, motor.stopped};
                REG_START_DURATION: rdata <= {6'h0, last_start_duration};
                REG_START_PEAK:     rdata <= {6'h0, last_start_peak_current};
                REG_LATEST_TRIP:    rdata <= {8'h0, latest_trip_code};
                REG_TRIP_CURRENT:   rdata <= {6'h0, current_at_trip};
                REG_RUN_HOURS:      rdata <= run_hours_total;
                REG_START_COUNT:    rdata <= start_count_total;
                REG_TRIP_COUNT:     rdata <= trip_count_total;
                default: begin
                    if (req.addr >= REG_HISTORY_BASE && req.addr <= REG_HISTORY_LAST) begin
                        if (req.addr == REG_HISTORY_BASE || advanced_mode_enable) begin
                            rdata <= {8'h0, trip_history[4'(req.addr - REG_HISTORY_BASE)]};
                        end
                    end
                end
            endcase
        end
    end

    chk_trip_history_shift: assert property (@(posedge clock) disable iff (!nrst)
        any_trip |=> trip_history[0] == $past(latest_trip_code))
        else $error("history entry one did not take the previous latest trip");

    chk_link_trip_code: assert property (@(posedge clock) disable iff (!nrst)
        link_trip |=> latest_trip_code == serial_link_fault_code)
        else $error("link timeout did not record serial link fault");

    chk_ramp_write_drop: assert property (@(posedge clock) disable iff (!nrst)
        (req.wr && req.from_serial && motor.soft_ramp && req.addr == REG_CMD_CHANNEL)
        |=> $stable(cmd_channel))
        else $error("serial write took effect during soft ramp");

    chk_remote_needs_input: assert property (@(posedge clock) disable iff (!nrst)
        !logic_input_one |=> !remote_run)
        else $error("remote run granted without logic input one");

    chk_trip_count_up: assert property (@(posedge clock) disable iff (!nrst)
        (any_trip && !history_counter_clear && trip_count_total != COUNT_MAX)
        |=> trip_count_total == $past(trip_count_total) + 16'h1)
        else $error("trip counter did not advance");

    chk_watch_off: assert property (@(posedge clock) disable iff (!nrst)
        !link_enabled |=> !link_timeout)
        else $error("link watch active with station off");

    chk_forced_reject: assert property (@(posedge clock) disable iff (!nrst)
        (req.wr && req.from_serial && forced_terminal_control) |-> illegal_function
        ##0 write_rejected)
        else $error("forced terminal write not rejected");

    chk_run_write_block: assert property (@(posedge clock) disable iff (!nrst)
        (req.wr && !motor.stopped && req.addr == REG_LINE_BIT_RATE)
        |=> $stable(line_bit_rate))
        else $error("setting changed while motor running");
endmodule : mcfg_bank

/* mcfg_master_model.sv */
// Serial master model that drives the register port
`timescale 1ns/1ns
module mcfg_master_model
    import mcfg_pkg::*;
(
    // Clock
    input  wire logic        clock,
    // Register port
    output mcfg_req_t        req,
    output logic             link_frame_ok,
    input  wire logic [15:0] rdata,
    input  wire logic        write_rejected,
    input  wire logic        illegal_function
);
    logic [15:0] data;
    logic        rej;
    logic        ill;
    initial begin
        req = '0;
        link_frame_ok = 1'b0;
    end
    task automatic access(input logic [7:0] a, input logic [15:0] d, input logic w);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: w, rd: !w, from_serial: 1'b1};
        link_frame_ok <= 1'b1;
        @(negedge clock);
        rej = write_rejected;
        ill = illegal_function;
        @(posedge clock);
        // Idle lines show the inverse so a stale value never passes
        req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0, from_serial: 1'b1};
        link_frame_ok <= 1'b0;
        #1 data = rdata;
    endtask : access
endmodule : mcfg_master_model

/* mcfg_bank_tb.sv */
// Self-checking bench for the register bank against a queue model
`timescale 1ns/1ns
module mcfg_bank_tb;
    import mcfg_pkg::*;
    logic        clock, nrst, logic_input_one, forced_terminal_control, remote_run_request;
    logic        write_rejected, illegal_function, remote_run, link_trip, link_enabled;
    logic        link_frame_ok;
    logic [15:0] rdata;
    logic [7:0]  active_station;
    logic [1:0]  active_bit_rate, active_format;
    mcfg_req_t   req;
    mcfg_motor_t motor;
    int          failures, cmp_count, cyc, latest, tcur, tcnt, scnt, peak, cur;
    int          hist[$] = '{0, 0, 0, 0, 0, 0, 0, 0, 0};
    mcfg_bank mcfg_bank_i (.clock(clock), .nrst(nrst), .req(req), .rdata(rdata),
        .write_rejected(write_rejected), .illegal_function(illegal_function), .motor(motor),
        .logic_input_one(logic_input_one), .forced_terminal_control(forced_terminal_control),
        .link_frame_ok(link_frame_ok), .remote_run_request(remote_run_request),
        .remote_run(remote_run), .link_trip(link_trip), .link_enabled(link_enabled),
        .active_station(active_station), .active_bit_rate(active_bit_rate),
        .active_format(active_format));
    mcfg_master_model m (.clock(clock), .req(req), .link_frame_ok(link_frame_ok),
        .rdata(rdata), .write_rejected(write_rejected), .illegal_function(illegal_function));
    task automatic wrap_up();
        if (failures == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        m.access(a, 16'h0000, 1'b0);
        chk(m.data, exp);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic rej);
        m.access(a, d, 1'b1);
        chk(16'(m.rej), 16'(rej));
    endtask : wr
    task automatic trip(input logic [7:0] c, input logic [9:0] i);
        @(posedge clock);
        motor.trip_event <= 1'b1;
        motor.trip_code <= c;
        motor.motor_current <= i;
        @(posedge clock);
        motor.trip_event <= 1'b0;
        hist.push_front(latest);
        void'(hist.pop_back());
        latest = c;
        tcur = (i > MEASURE_MAX) ? int'(MEASURE_MAX) : int'(i);
        tcnt++;
    endtask : trip
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Bound sized well above the few hundred cycles the sequence needs
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        nrst = 1'b0;
        motor = '0;
        motor.stopped = 1'b1;
        logic_input_one = 1'b0;
        forced_terminal_control = 1'b0;
        remote_run_request = 1'b0;
        void'($urandom(32'hBB24));
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(negedge clock);
        chk(16'(active_bit_rate), 16'(RATE_19K2));
        chk(16'(active_format), 16'(FMT_EIGHT_EVEN_ONE));
        rd(REG_STATION_ADDR, 16'(STATION_OFF));
        rd(REG_LINK_WATCH, 16'(WATCH_DEFAULT));
        rd(REG_CMD_CHANNEL, 16'(CHAN_TERMINAL));
        wr(REG_STATION_ADDR, 16'(STATION_MAX), 1'b0);
        rd(REG_STATION_ADDR, 16'(STATION_MAX));
        m.access(REG_STATION_ADDR, 16'h00F8, 1'b1);
        rd(REG_STATION_ADDR, 16'(STATION_MAX));
        chk(16'(active_station), 16'h0000);
        chk(16'(link_enabled), 16'h0000);
        chk(16'(link_trip), 16'h0000);
        for (int f = 0; f < 4; f++) begin
            wr(REG_CHAR_FORMAT, 16'(f), 1'b0);
            rd(REG_CHAR_FORMAT, 16'(f));
            if (f < 3) wr(REG_LINE_BIT_RATE, 16'(f), 1'b0);
            if (f < 3) rd(REG_LINE_BIT_RATE, 16'(f));
        end
        chk(16'(active_format), 16'(FMT_EIGHT_EVEN_ONE));
        wr(REG_CHAR_FORMAT, 16'(FMT_EIGHT_EVEN_ONE), 1'b0);
        wr(REG_LINK_WATCH, 16'(WATCH_MIN), 1'b0);
        rd(REG_LINK_WATCH, 16'(WATCH_MIN));
        chk(16'(active_bit_rate), 16'(RATE_19K2));
        @(posedge clock) motor.stopped <= 1'b0;
        wr(REG_LINE_BIT_RATE, 16'(RATE_4K8), 1'b1);
        rd(REG_LINE_BIT_RATE, 16'(RATE_19K2));
        @(posedge clock) {motor.stopped, motor.soft_ramp} <= 2'h3;
        wr(REG_CMD_CHANNEL, 16'h0001, 1'b1);
        rd(REG_CMD_CHANNEL, 16'(CHAN_TERMINAL));
        @(posedge clock) {motor.stopped, motor.soft_ramp, forced_terminal_control} <= 3'h5;
        wr(REG_CMD_CHANNEL, 16'h0001, 1'b1);
        chk(16'(m.ill), 16'h0001);
        rd(REG_CMD_CHANNEL, 16'(CHAN_TERMINAL));
        @(posedge clock) forced_terminal_control <= 1'b0;
        wr(REG_CMD_CHANNEL, 16'(CHAN_SERIAL), 1'b0);
        @(posedge clock) {logic_input_one, remote_run_request} <= 2'h3;
        repeat (2) @(posedge clock);
        chk(16'(remote_run), 16'h0001);
        logic_input_one <= 1'b0;
        repeat (2) @(posedge clock);
        chk(16'(remote_run), 16'h0000);
        {motor.stopped, motor.running, motor.start_begin} <= 3'h3;
        peak = 0;
        repeat (6) begin
            @(posedge clock) motor.start_begin <= 1'b0;
            cur = $urandom % 1000;
            motor.motor_current <= 10'(cur);
            if (cur > peak) peak = cur;
        end
        @(posedge clock) motor.start_done <= 1'b1;
        @(posedge clock) {motor.start_done, motor.stopped, motor.running} <= 3'h2;
        scnt++;
        rd(REG_START_PEAK, 16'(peak));
        rd(REG_START_DURATION, 16'h0000);
        rd(REG_START_COUNT, 16'(scnt));
        repeat (10) trip(8'($urandom), 10'($urandom % 1000));
        trip(8'h21, 10'h3FF);
        rd(REG_LATEST_TRIP, 16'(latest));
        rd(REG_TRIP_CURRENT, 16'(tcur));
        rd(REG_TRIP_COUNT, 16'(tcnt));
        rd(REG_RUN_HOURS, 16'h0000);
        rd(REG_STATUS, 16'h0001);
        for (int a = 0; a < 2; a++) begin
            for (int i = 0; i < 9; i++)
                rd(8'(REG_HISTORY_BASE + i), (i == 0 || a == 1) ? 16'(hist[i]) : 16'h0000);
            wr(REG_ADVANCED_MODE, 16'h0001, 1'b0);
        end
        wr(REG_HIST_CLEAR, 16'(HIST_CLEAR_KEY), 1'b0);
        rd(REG_TRIP_COUNT, 16'h0000);
        rd(REG_START_COUNT, 16'h0000);
        rd(REG_RUN_HOURS, 16'h0000);
        rd(REG_HISTORY_BASE, 16'h0000);
        rd(8'h30, 16'h0000);
        wrap_up();
    end
endmodule : mcfg_bank_tb
